// file: common/bbc_pkg.sv
// Purpose: shared constants and carriers of the buffered-module branch scheduler
// Assumes: 250 MHz hclk, 32-bit AHB-Lite register access
// Notes:   cfg_t fixes the bit layout of the configuration word
package bbc_pkg;
    localparam logic [7:0]  CFG_OFS       = 8'h00;
    localparam logic [7:0]  STAT_OFS      = 8'h04;
    localparam int          CLK_MHZ       = 250;
    localparam int          REF_SLOW_NS   = 15600;
    localparam int          REF_FAST_NS   = 7800;
    // longest interval: integer division rounds down
    localparam int          REF_SLOW_CYC  = REF_SLOW_NS * CLK_MHZ / 1000;
    localparam int          REF_FAST_CYC  = REF_FAST_NS * CLK_MHZ / 1000;
    localparam int          FRAME_CYC     = 12;
    localparam int          BANK_BUSY_FR  = 4;
    localparam int          BL_DUAL       = 4;
    localparam int          BL_SINGLE     = 8;
    localparam int          FR_DUAL       = 4;
    localparam int          FR_SINGLE     = 8;
    localparam logic [31:0] CFG_RST       = 32'h0000_EB00;

    typedef enum logic [2:0] {CK_NOP, CK_ACT, CK_RD, CK_WR, CK_REF} bbc_kind_t;

    typedef struct packed {
        logic [15:0] rsvd;
        logic [3:0]  ras_w;
        logic [3:0]  cas_w;
        logic [1:0]  rsvd_lo;
        logic        stacked;
        logic        eight_bank;
        logic        ext_ecc;
        logic        x8;
        logic        ref_fast;
        logic        dual;
    } bbc_cfg_t;

    typedef struct packed {
        logic        write;
        logic [3:0]  rank;
        logic [2:0]  bank;
        logic [14:0] row;
        logic [10:0] col;
    } bbc_req_t;

    typedef struct packed {
        bbc_kind_t   kind;
        logic [1:0]  cs;
        logic [1:0]  chan_en;
        logic [2:0]  dimm;
        logic [2:0]  bank;
        logic [14:0] addr;
        logic        auto_pre;
        logic [3:0]  beats;
    } bbc_cmd_t;

    typedef struct packed {
        logic [127:0] data;
        logic [15:0]  check;
    } bbc_wframe_t;
endpackage

// file: rtl/bbc_branch.sv
// Purpose: one branch scheduler: frames, refresh, rank gaps, ECC, line assembly
// Assumes: request, read and write-beat ports come from logic on hclk
// Notes:   one instance per branch; instances share nothing
//
// Overview of operation
// - every read or write carries auto-precharge; no bank stays open
// - burst of four beats in dual-channel mode, eight in single
// - one idle frame between ranks on opposite sides of one module
// - four branches run independently, one instance each
// - dual mode drives both channels in lock-step as one rank
// - line returns as eight frames single, four frames dual
// - commands issue only on twelve-cycle frame boundaries
// - refresh at least every 15.6 or 7.8 microseconds
// - a frame flagged with CRC error is sent again
// - single-rank modules get both chip selects; double-rank one each
// - four-bit rank index covers sixteen ranks over eight modules
// - x4 and x8 supported; extended ECC refused with x8 parts
// - densities 256 Mbit to 2 Gbit; 512 MB to 128 GB per branch
// - sixteen bytes per half clock dual, eight bytes single
// - each internal bank tracked and may overlap with others
// - sixteen check bits per 128 data bits, generated and checked
`timescale 1ns/1ps
`default_nettype none
module bbc_branch #(
    parameter int BUSY_FR = bbc_pkg::BANK_BUSY_FR
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    input  wire logic                 req_valid,
    output logic                      req_ready,
    input  wire bbc_pkg::bbc_req_t    req,
    output logic                      frame_start,
    output logic                      cmd_valid,
    output logic                      cmd_retry,
    output bbc_pkg::bbc_cmd_t         cmd,
    input  wire logic                 crc_err,
    input  wire logic                 wr_beat_valid,
    input  wire logic [127:0]         wr_beat,
    output logic                      wr_frame_valid,
    output bbc_pkg::bbc_wframe_t      wr_frame,
    input  wire logic                 rd_valid,
    input  wire logic [287:0]         rd_data,
    output logic                      rd_line_valid,
    output logic [511:0]              rd_line,
    output logic                      rd_ecc_err
);
    if (BUSY_FR < 1 || BUSY_FR > 15) begin : g_busy_chk
        $error("BUSY_FR out of range");
    end

    typedef enum logic [0:0] {ST_IDLE, ST_CAS} bbc_state_t;

    typedef struct packed {
        bbc_state_t         st;
        logic [3:0]         fcnt;
        logic [11:0]        rcnt;
        logic               ref_due;
        logic               retry;
        logic               gap_done;
        logic               dual;
        logic [3:0]         last_rank;
        logic               last_valid;
        logic [7:0][3:0]    busy;
        bbc_pkg::bbc_req_t  cur;
        bbc_pkg::bbc_cfg_t  cfg;
        logic               ecc_err;
        logic               aw_pend;
        logic [7:0]         aw_addr;
        logic [31:0]        rdata;
        logic               cmd_valid;
        logic               cmd_retry;
        bbc_pkg::bbc_cmd_t  cmd;
        logic               wf_valid;
        bbc_pkg::bbc_wframe_t wf;
        logic [2:0]         rd_idx;
        logic               line_valid;
        logic [511:0]       line;
    } bbc_st_t;

    bbc_st_t s;         // one copy per branch: no shared state
    bbc_st_t next_s;

    // byte parity per 8 data bits: 16 check bits per 128
    function automatic logic [15:0] ecc128(input logic [127:0] d);
        logic [15:0] c;
        c = '0;
        for (int i = 0; i < 16; i++) begin
            c[i] = ^d[i*8 +: 8];
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic       boundary;
    logic       ext_ok;
    logic       switch_gap;
    logic [2:0] bidx;
    logic [3:0] n_frames;
    logic [11:0] ref_lim;
    bbc_pkg::bbc_cmd_t act_cmd;
    bbc_pkg::bbc_cmd_t cas_cmd;

    assign boundary  = (s.fcnt == 4'd0);
    assign ext_ok    = s.cfg.ext_ecc & ~s.cfg.x8;
    assign bidx      = s.cfg.eight_bank ? req.bank : {1'b0, req.bank[1:0]};
    assign n_frames  = s.dual ? 4'(bbc_pkg::FR_DUAL) : 4'(bbc_pkg::FR_SINGLE);
    assign ref_lim   = s.cfg.ref_fast ? 12'(bbc_pkg::REF_FAST_CYC)
                                      : 12'(bbc_pkg::REF_SLOW_CYC);
    // same module, other side, stacked modules only
    assign switch_gap = s.cfg.stacked && s.last_valid && !s.gap_done
                        && req.rank[3:1] == s.last_rank[3:1]
                        && req.rank[0] != s.last_rank[0];
    assign req_ready = boundary && !s.retry && !s.ref_due && s.st == ST_IDLE
                       && !switch_gap && s.busy[bidx] == 4'd0;

    always_comb begin
        act_cmd          = '0;
        act_cmd.kind     = bbc_pkg::CK_ACT;
        act_cmd.dimm     = req.rank[3:1];
        act_cmd.cs       = !s.cfg.stacked ? 2'b11
                         : (req.rank[0] ? 2'b10 : 2'b01);
        // mode latched at this same boundary applies to this command
        act_cmd.chan_en  = s.cfg.dual ? 2'b11 : 2'b01;
        act_cmd.bank     = bidx;
        act_cmd.addr     = req.row;
        cas_cmd          = s.cmd;
        cas_cmd.kind     = s.cur.write ? bbc_pkg::CK_WR : bbc_pkg::CK_RD;
        cas_cmd.addr     = {4'h0, s.cur.col};
        cas_cmd.auto_pre = 1'b1;
        cas_cmd.beats    = s.dual ? 4'(bbc_pkg::BL_DUAL) : 4'(bbc_pkg::BL_SINGLE);
    end

    ////////////////////////////////////////////////////////////////////////////
    logic        a_phase;
    logic [15:0] rd_chk;
    logic [15:0] rd_calc;
    logic [127:0] rd_word;

    assign a_phase = hsel && htrans[1] && hready;
    // single mode carries 64 data bits per frame, dual 128
    assign rd_word = s.dual ? rd_data[127:0] : {64'h0000_0000_0000_0000, rd_data[63:0]};
    assign rd_chk  = s.dual ? rd_data[143:128] : {8'h00, rd_data[71:64]};
    assign rd_calc = ecc128(rd_word);

    always_comb begin
        next_s            = s;
        next_s.cmd_valid  = 1'b0;
        next_s.cmd_retry  = 1'b0;
        next_s.wf_valid   = 1'b0;
        next_s.line_valid = 1'b0;
        next_s.fcnt = (s.fcnt == 4'(bbc_pkg::FRAME_CYC - 1)) ? 4'd0 : s.fcnt + 4'd1;
        // refresh timer; due flag holds until a refresh frame goes out
        if (s.rcnt >= ref_lim - 12'd1) begin
            next_s.rcnt    = 12'd0;
        end else begin
            next_s.rcnt = s.rcnt + 12'd1;
        end
        if (boundary) begin
            for (int b = 0; b < 8; b++) begin
                if (s.busy[b] != 4'd0) next_s.busy[b] = s.busy[b] - 4'd1;
            end
        end
        if (boundary && s.retry) begin
            next_s.cmd_valid = 1'b1;
            next_s.cmd_retry = 1'b1;
            next_s.retry     = 1'b0;
        end else if (boundary) begin
            unique case (s.st)
                ST_IDLE: begin
                    next_s.dual = s.cfg.dual;
                    if (s.ref_due) begin
                        next_s.cmd         = '0;
                        next_s.cmd.kind    = bbc_pkg::CK_REF;
                        next_s.cmd.cs      = 2'b11;
                        next_s.cmd.chan_en = s.cfg.dual ? 2'b11 : 2'b01;
                        next_s.cmd_valid   = 1'b1;
                        next_s.ref_due     = 1'b0;
                        next_s.gap_done    = 1'b0;
                    end else if (req_valid && switch_gap) begin
                        next_s.cmd       = '0;
                        next_s.cmd_valid = 1'b1;
                        next_s.gap_done  = 1'b1;
                    end else if (req_valid && req_ready) begin
                        next_s.cmd        = act_cmd;
                        next_s.cmd_valid  = 1'b1;
                        next_s.cur        = req;
                        next_s.last_rank  = req.rank;
                        next_s.last_valid = 1'b1;
                        next_s.gap_done   = 1'b0;
                        next_s.busy[bidx] = 4'(BUSY_FR);
                        next_s.st         = ST_CAS;
                    end
                end
                ST_CAS: begin
                    next_s.cmd       = cas_cmd;
                    next_s.cmd_valid = 1'b1;
                    // a write must not cut a line still returning
                    if (!s.cur.write) next_s.rd_idx = 3'd0;
                    next_s.st        = ST_IDLE;
                end
            endcase
        end
        // set wins over the clear above
        if (s.rcnt >= ref_lim - 12'd1) next_s.ref_due = 1'b1;
        if (crc_err) next_s.retry = 1'b1;
        if (wr_beat_valid) begin
            next_s.wf_valid    = 1'b1;
            next_s.wf.data     = wr_beat;
            next_s.wf.check    = ecc128(wr_beat);
        end
        if (rd_valid) begin
            if (s.dual) next_s.line[s.rd_idx[1:0]*128 +: 128] = rd_word;
            else        next_s.line[s.rd_idx*64 +: 64] = rd_word[63:0];
            if (rd_chk != rd_calc) next_s.ecc_err = 1'b1;
            if ({1'b0, s.rd_idx} == n_frames - 4'd1) begin
                next_s.rd_idx     = 3'd0;
                next_s.line_valid = 1'b1;
            end else begin
                next_s.rd_idx = s.rd_idx + 3'd1;
            end
        end
        // AHB-Lite: write lands in the data phase, read data prepared early
        next_s.aw_pend = a_phase && hwrite;
        next_s.aw_addr = haddr[7:0];
        if (s.aw_pend && s.aw_addr == bbc_pkg::CFG_OFS) begin
            next_s.cfg = bbc_pkg::bbc_cfg_t'(hwdata);
            next_s.cfg.rsvd    = '0;
            next_s.cfg.rsvd_lo = '0;
            if (hwdata[3] && hwdata[2]) next_s.cfg.ext_ecc = 1'b0;
        end
        if (s.aw_pend && s.aw_addr == bbc_pkg::STAT_OFS && hwdata[3]) begin
            next_s.ecc_err = rd_valid && rd_chk != rd_calc;                 // new error wins
        end
        if (a_phase && !hwrite) begin
            unique case (haddr[7:0])
                bbc_pkg::CFG_OFS:  next_s.rdata = s.cfg;
                bbc_pkg::STAT_OFS: next_s.rdata = {27'h0, s.ecc_err, ext_ok, s.ref_due,
                                                   s.dual, s.st == ST_IDLE};
                default:           next_s.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s     <= '0;
            s.cfg <= bbc_pkg::bbc_cfg_t'(bbc_pkg::CFG_RST);
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign hrdata         = s.rdata;
    assign frame_start    = boundary;
    assign cmd_valid      = s.cmd_valid;
    assign cmd_retry      = s.cmd_retry;
    assign cmd            = s.cmd;
    assign wr_frame_valid = s.wf_valid;
    assign wr_frame       = s.wf;
    assign rd_line_valid  = s.line_valid;
    assign rd_line        = s.line;
    assign rd_ecc_err     = s.ecc_err;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    logic cas_out;
    assign cas_out = cmd_valid && (cmd.kind == bbc_pkg::CK_RD || cmd.kind == bbc_pkg::CK_WR);

    AST_AUTOPRE: assert property (@(posedge hclk) disable iff (!hresetn)
        cas_out |-> cmd.auto_pre) else $error("access without auto-precharge");
    AST_BURST: assert property (@(posedge hclk) disable iff (!hresetn)
        cas_out |-> cmd.beats == (s.dual ? 4'd4 : 4'd8)) else $error("wrong burst");
    AST_GAP: assert property (@(posedge hclk) disable iff (!hresetn)
        (cmd_valid && !cmd_retry && cmd.kind == bbc_pkg::CK_NOP)
        |-> ##12 !(cmd_valid && !cmd_retry && cmd.kind == bbc_pkg::CK_NOP))
        else $error("more than one gap frame");
    AST_FRAME: assert property (@(posedge hclk) disable iff (!hresetn)
        frame_start |=> !frame_start [*8] ##1 !frame_start [*3] ##1 frame_start)
        else $error("frame period not twelve");
    AST_LOCKSTEP: assert property (@(posedge hclk) disable iff (!hresetn)
        (cmd_valid && cmd.kind != bbc_pkg::CK_NOP) |-> cmd.chan_en == (s.dual ? 2'b11 : 2'b01))
        else $error("channel enables wrong");
    AST_CS: assert property (@(posedge hclk) disable iff (!hresetn)
        (cmd_valid && cmd.kind == bbc_pkg::CK_ACT && !s.cfg.stacked) |-> cmd.cs == 2'b11)
        else $error("single-rank module missing chip select");
    AST_REFRESH: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(s.ref_due) |-> ##[1:40] (cmd_valid && cmd.kind == bbc_pkg::CK_REF))
        else $error("refresh late");
    AST_RETRY: assert property (@(posedge hclk) disable iff (!hresetn)
        crc_err |-> ##[1:13] cmd_retry) else $error("no retransmit");
    AST_LINE: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_valid && {1'b0, s.rd_idx} == n_frames - 4'd1) |=> rd_line_valid)
        else $error("line not completed");
    AST_X8: assert property (@(posedge hclk) disable iff (!hresetn)
        !(s.cfg.x8 && s.cfg.ext_ecc)) else $error("extended ECC with x8");

    COV_READ:  cover property (@(posedge hclk) cas_out && cmd.kind == bbc_pkg::CK_RD);
    COV_WRITE: cover property (@(posedge hclk) cas_out && cmd.kind == bbc_pkg::CK_WR);
    COV_REF:   cover property (@(posedge hclk) cmd_valid && cmd.kind == bbc_pkg::CK_REF);
    COV_RETRY: cover property (@(posedge hclk) cmd_retry);
endmodule
`default_nettype wire

// file: tb/bbc_link_model.sv
// Purpose: far-side module chain: read frames and crc error flags
// Assumes: one read return per read command, one frame per 12 cycles
// Notes:   idle data lines toggle so a stale frame never matches
`timescale 1ns/1ps
`default_nettype none
module bbc_link_model (
    input  wire logic              hclk,
    input  wire logic              cmd_valid,
    input  wire logic              cmd_retry,
    input  wire bbc_pkg::bbc_cmd_t cmd,
    input  wire logic [31:0]       seed,
    input  wire logic              bad_ecc,
    input  wire logic              crc_req,
    input  wire logic [7:0]        lag,
    output logic                   crc_err,
    output logic                   rd_valid,
    output logic [287:0]           rd_data
);
    int           left = 0, gap = 0, idx = 0;
    logic         dual_m = 1'b0;
    logic [127:0] d;
    logic [15:0]  chk;
    initial begin
        crc_err = 1'b0;
        rd_valid = 1'b0;
        rd_data = '0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge hclk) begin
        crc_err <= cmd_valid && !cmd_retry && crc_req && cmd.kind == bbc_pkg::CK_ACT;
        rd_valid <= 1'b0;
        rd_data <= ~rd_data;
        if (cmd_valid && !cmd_retry && cmd.kind == bbc_pkg::CK_RD) begin
            left = (cmd.beats == 4'h4) ? 4 : 8;
            dual_m = (cmd.beats == 4'h4);
            gap = 12 + 32'(lag);
            idx = 0;
        end else if (left > 0) begin
            gap = gap - 1;
            if (gap == 0) begin
                d = {4{seed ^ 32'(idx)}};
                for (int i = 0; i < 16; i++)
                    chk[i] = ^d[i*8 +: 8] ^ bad_ecc;
                if (dual_m)
                    rd_data[143:0] <= {chk, d};
                else
                    rd_data[71:0] <= {chk[7:0], d[63:0]};
                rd_valid <= 1'b1;
                gap = 12;
                idx = idx + 1;
                left = left - 1;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/test_bbc_branch.sv
// Purpose: self-checking bench of one branch scheduler
// Assumes: bank busy cut to one frame to keep the run short
// Notes:   drivers note expectations in queues; one monitor pops them
`timescale 1ns/1ps
`default_nettype none
module test_bbc_branch;
    typedef struct packed {
        bbc_pkg::bbc_kind_t kind;
        logic               retry, dual, stk;
        logic [3:0]         rank;
        logic [2:0]         bank;
        logic [14:0]        adr;
    } bbc_exp_t;
    logic                 hclk, hresetn, hsel, hwrite, hreadyout, hresp, req_valid, req_ready;
    logic                 frame_start, cmd_valid, cmd_retry, crc_err, wr_beat_valid, crc_req;
    logic                 wr_frame_valid, rd_valid, rd_line_valid, rd_ecc_err, bad_ecc;
    logic [1:0]           htrans;
    logic [2:0]           hsize;
    logic [7:0]           lag;
    logic [31:0]          haddr, hwdata, hrdata, seed, r;
    logic [31:0]          st = 32'h0000_0050;
    logic [127:0]         wr_beat, w;
    logic [287:0]         rd_data;
    logic [511:0]         rd_line;
    logic [511:0]         lq[$];
    bbc_pkg::bbc_req_t    req;
    bbc_pkg::bbc_cmd_t    cmd;
    bbc_pkg::bbc_wframe_t wr_frame;
    bbc_pkg::bbc_wframe_t wq[$];
    bbc_exp_t             cq[$], e;
    int                   n_fail = 0, samples_checked = 0, cyc = 0, fs_last = 0, n_ref = 0;
    int                   last_ref = 0, ref_lim = bbc_pkg::REF_SLOW_CYC + 36;

    bbc_branch #(.BUSY_FR(1)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .frame_start(frame_start), .cmd_valid(cmd_valid),
        .cmd_retry(cmd_retry), .cmd(cmd), .crc_err(crc_err), .wr_beat_valid(wr_beat_valid),
        .wr_beat(wr_beat), .wr_frame_valid(wr_frame_valid), .wr_frame(wr_frame),
        .rd_valid(rd_valid), .rd_data(rd_data), .rd_line_valid(rd_line_valid),
        .rd_line(rd_line), .rd_ecc_err(rd_ecc_err));
    bbc_link_model i_link (
        .hclk(hclk), .cmd_valid(cmd_valid), .cmd_retry(cmd_retry), .cmd(cmd), .seed(seed),
        .bad_ecc(bad_ecc), .crc_req(crc_req), .lag(lag), .crc_err(crc_err),
        .rd_valid(rd_valid), .rd_data(rd_data));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction
    function automatic logic [15:0] par(logic [127:0] d);
        for (int i = 0; i < 16; i++)
            par[i] = ^d[i*8 +: 8];
    endfunction
    function automatic logic [511:0] line(logic dual);
        for (int i = 0; i < 8; i++)
            if (!dual)
                line[i*64 +: 64] = {2{seed ^ i}};
            else if (i < 4)
                line[i*128 +: 128] = {4{seed ^ i}};
    endfunction
    task automatic check(string nm, logic [511:0] seen, logic [511:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic ahb(logic wr, logic [31:0] a, logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check("hresp", hresp, 1'b0);
    endtask
    task automatic set_cfg(logic dual, logic stk, logic fast);
        // one set per branch: x4 part, ras E, cas B
        ahb(1'b1, 32'(bbc_pkg::CFG_OFS), {16'h0000, 8'hEB, 2'b00, stk, 3'b000, fast, dual}, r);
        repeat (24) @(posedge hclk); // mode only latched at an idle boundary
        last_ref = 0;
        ref_lim = (fast ? bbc_pkg::REF_FAST_CYC : bbc_pkg::REF_SLOW_CYC) + 36;
    endtask
    task automatic send(logic wr, logic [3:0] rk, logic [2:0] bk, logic dual, logic stk,
                        logic crc, logic gap);
        int k;
        bbc_pkg::bbc_req_t q;
        k = 0;
        q = '{wr, rk, bk, 15'(rnd()), 11'(rnd())};
        if (gap) cq.push_back('{bbc_pkg::CK_NOP, 1'b0, dual, stk, rk, bk, q.row});
        req <= q;
        req_valid <= 1'b1;
        crc_req <= crc;
        do begin
            @(posedge hclk);
            k++;
        end while (req_ready !== 1'b1 && k < 400);
        req_valid <= 1'b0;
        check("req_taken", k < 400, 1'b1);
        cq.push_back('{bbc_pkg::CK_ACT, 1'b0, dual, stk, rk, bk, q.row});
        if (crc) cq.push_back('{bbc_pkg::CK_ACT, 1'b1, dual, stk, rk, bk, q.row});
        cq.push_back('{wr ? bbc_pkg::CK_WR : bbc_pkg::CK_RD, 1'b0, dual, stk, rk, bk,
                       {4'h0, q.col}});
        if (!wr) lq.push_back(line(dual));
        repeat (2) @(posedge hclk);
        crc_req <= 1'b0;
    endtask
    task automatic drain();
        int k;
        k = 0;
        while ((lq.size() + cq.size() + wq.size()) > 0 && k < 600) begin
            @(posedge hclk);
            k++;
        end
        check("drained", k < 600, 1'b1);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge hclk) begin
        cyc++;
        if (!hresetn) begin
            fs_last = 0;
        end else begin
            if (frame_start === 1'b1) begin
                if (fs_last > 0) check("frame_gap", cyc - fs_last, 12);
                fs_last = cyc;
            end
            if (cmd_valid === 1'b1 && cmd.kind === bbc_pkg::CK_REF) begin
                check("ref_cs", cmd.cs, 2'b11);
                if (last_ref > 0) check("ref_gap", cyc - last_ref <= ref_lim, 1'b1);
                last_ref = cyc;
                n_ref++;
            end else if (cmd_valid === 1'b1 && cq.size() == 0) begin
                check("cmd_extra", 1'b1, 1'b0);
            end else if (cmd_valid === 1'b1) begin
                e = cq.pop_front();
                check("cmd_kind", cmd.kind, e.kind);
                check("cmd_retry", cmd_retry, e.retry);
                if (e.kind != bbc_pkg::CK_NOP) begin
                    check("cmd_bank", cmd.bank, e.bank);
                    check("cmd_addr", cmd.addr, e.adr);
                    if (e.dual) check("chan_en", cmd.chan_en, 2'b11);
                    else check("chan_one", $countones(cmd.chan_en), 1);
                    if (e.stk) check("cs_one", $countones(cmd.cs), 1);
                    else check("cs_both", cmd.cs, 2'b11);
                    if (e.stk) check("dimm", cmd.dimm, e.rank[3:1]);
                end
                if (e.kind == bbc_pkg::CK_RD || e.kind == bbc_pkg::CK_WR) begin
                    check("auto_pre", cmd.auto_pre, 1'b1);
                    check("beats", cmd.beats, e.dual ? 4'h4 : 4'h8);
                end
            end
            if (rd_line_valid === 1'b1 && lq.size() == 0) check("line_extra", 1'b1, 1'b0);
            else if (rd_line_valid === 1'b1) check("rd_line", rd_line, lq.pop_front());
            if (wr_frame_valid === 1'b1 && wq.size() == 0) check("wr_extra", 1'b1, 1'b0);
            else if (wr_frame_valid === 1'b1) check("wr_frame", wr_frame, wq.pop_front());
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    initial begin
        #(4 * 40000);
        check("timeout", 1'b1, 1'b0);
        wrap_up();
    end
    initial begin
        {hresetn, hsel, hwrite, req_valid, wr_beat_valid, bad_ecc, crc_req, htrans, hsize} = '0;
        {lag, haddr, hwdata, seed, wr_beat, req} = '0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, 32'(bbc_pkg::CFG_OFS), '0, r);
        check("cfg_reset", r, bbc_pkg::CFG_RST);
        ahb(1'b0, 32'h0000_0008, '0, r);
        check("unmapped", r, 32'h0000_0000);
        ahb(1'b1, 32'(bbc_pkg::CFG_OFS), 32'h0000_EB0C, r);
        ahb(1'b0, 32'(bbc_pkg::CFG_OFS), '0, r);
        check("ext_ecc_x8", r, 32'h0000_EB04);
        ahb(1'b1, 32'(bbc_pkg::CFG_OFS), 32'h0000_EB08, r);
        ahb(1'b0, 32'(bbc_pkg::STAT_OFS), '0, r);
        check("ext_ecc_x4", r[3], 1'b1);
        set_cfg(1'b0, 1'b0, 1'b0);
        seed = rnd();
        send(1'b0, 4'h0, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0);
        send(1'b1, 4'h1, 3'h2, 1'b0, 1'b0, 1'b1, 1'b0);
        drain();
        set_cfg(1'b1, 1'b0, 1'b0);
        for (int i = 0; i < 2; i++) begin
            seed = rnd();
            lag <= 8'(i * 13); // late return from the far side
            send(1'b0, 4'(i + 2), 3'(i), 1'b1, 1'b0, 1'b0, 1'b0);
            drain();
        end
        check("ecc_clean", rd_ecc_err, 1'b0);
        bad_ecc <= 1'b1;
        seed = rnd();
        send(1'b0, 4'h4, 3'h3, 1'b1, 1'b0, 1'b0, 1'b0);
        drain();
        check("ecc_flag", rd_ecc_err, 1'b1);
        ahb(1'b1, 32'(bbc_pkg::STAT_OFS), 32'h0000_0008, r);
        @(posedge hclk);
        check("ecc_clear", rd_ecc_err, 1'b0);
        bad_ecc <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            w = {rnd(), rnd(), rnd(), rnd()};
            wr_beat <= w;
            wr_beat_valid <= 1'b1;
            wq.push_back({w, par(w)});
            @(posedge hclk);
        end
        wr_beat_valid <= 1'b0;
        drain();
        set_cfg(1'b0, 1'b1, 1'b0);
        seed = rnd();
        send(1'b1, 4'hE, 3'h0, 1'b0, 1'b1, 1'b0, 1'b0);
        send(1'b1, 4'hF, 3'h1, 1'b0, 1'b1, 1'b0, 1'b1);
        send(1'b0, 4'hF, 3'h2, 1'b0, 1'b1, 1'b0, 1'b0);
        drain();
        set_cfg(1'b0, 1'b0, 1'b0);
        repeat (8000) @(posedge hclk); // two slow refresh intervals
        set_cfg(1'b0, 1'b0, 1'b1);
        repeat (4000) @(posedge hclk); // two fast refresh intervals
        check("ref_seen", n_ref >= 4, 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
